/* File: hw/dcs_control.sv */
`timescale 1ns/1ps
module dcs_control
    import dcs_pkg::*;
#(
    parameter int WORD_W = 16
) (
    input  wire logic              clk,
    input  wire logic              arst_n,
    input  wire logic              cmdStrobe,
    input  wire logic [15:0]       commandWord,
    input  wire logic [15:0]       busReference,
    input  wire logic [15:0]       presetRef0,
    input  wire logic [15:0]       presetRef1,
    input  wire logic [15:0]       presetRef2,
    input  wire logic [15:0]       presetRef3,
    input  wire logic [15:0]       jogSpeed,
    input  wire logic [15:0]       outputFreq,
    input  dcs_pkg::dcs_cfg_t      cfg,
    input  dcs_pkg::dcs_drv_stat_t drv,
    output dcs_pkg::dcs_act_t      act,
    output logic [15:0]            statusWord,
    output logic [15:0]            actualValueWord
);
    // refused at elaboration: the word layout is fixed at sixteen bits
    if (WORD_W != 16) begin : g_width_check
        $error("dcs_control supports only 16-bit words");
    end

    typedef struct packed {
        logic [15:0] cmd;
        logic [15:0] ref16;
        logic        resetPrev;
        dcs_act_t    act;
        logic [15:0] actual;
    } dcs_state_t;

    dcs_state_t st;
    dcs_state_t next_st;
    logic       stopReq;
    logic       frozen;
    logic       revAllowed;
    logic [15:0] selRef;

    dcs_status_word u_status (
        .clk        (clk),
        .arst_n     (arst_n),
        .drv        (drv),
        .statusWord (statusWord)
    );

    always_comb begin
        next_st = st;
        // only valid words are taken; invalid ones leave the stored word and reference intact
        if (cmdStrobe && commandWord[CMD_VALID]) begin
            next_st.cmd   = commandWord;
            next_st.ref16 = busReference;
        end
        frozen = ~st.cmd[CMD_NO_HOLD];
        stopReq = ~st.cmd[CMD_NO_COAST] | ~st.cmd[CMD_NO_DCBRK]
                | cfg.dinDcBrake | cfg.dinCoast
                | cfg.dinResetCoast;
        unique case ({st.cmd[CMD_REF_HI], st.cmd[CMD_REF_LO]})
            2'b00:   selRef = presetRef0;
            2'b01:   selRef = presetRef1;
            2'b10:   selRef = presetRef2;
            default: selRef = presetRef3;
        endcase
        revAllowed = (cfg.revSrc == DCS_REV_SERIAL)
                   | (cfg.revSrc == DCS_REV_AND & cfg.revInput)
                   | (cfg.revSrc == DCS_REV_OR);

        next_st.act.presetSel = {st.cmd[CMD_REF_HI], st.cmd[CMD_REF_LO]};
        next_st.act.jog   = st.cmd[CMD_JOG];
        next_st.act.ramp2 = st.cmd[CMD_RAMP2];
        next_st.act.reverse = (revAllowed & st.cmd[CMD_REVERSE])
                | (cfg.revSrc == DCS_REV_OR & cfg.revInput)
                | (cfg.revSrc == DCS_REV_DIN & cfg.revInput);
        next_st.act.relay1 = (cfg.relay1Fn == RELAY1_FN_CW11)
                           & st.cmd[CMD_RELAY1];
        next_st.act.relay4 = (cfg.relay4Fn == RELAY4_FN_CW12)
                           & st.cmd[CMD_RELAY4];
        if (cfg.activeSetup == SETUP_MULTI) begin
            next_st.act.setupSel = {st.cmd[CMD_SETUP_HI],
                                    st.cmd[CMD_SETUP_LO]};
        end
        next_st.resetPrev = st.cmd[CMD_RESET];
        next_st.act.tripReset = st.cmd[CMD_RESET]
                              & ~st.resetPrev;

        next_st.act.outputEnable = 1'b1;
        next_st.act.rampEnable   = 1'b1;
        if (!st.cmd[CMD_NO_COAST] || cfg.dinCoast
                || cfg.dinResetCoast) begin
            next_st.act.mode = DCS_COAST;
            next_st.act.outputEnable = 1'b0;
            next_st.act.rampEnable   = 1'b0;
        end else if (!st.cmd[CMD_NO_DCBRK] || cfg.dinDcBrake) begin
            next_st.act.mode = DCS_DC_BRAKE;
            next_st.act.rampEnable = 1'b0;
        end else if (frozen && !stopReq) begin
            // hold ignores quick stop and ramp stop while frozen
            next_st.act.mode = DCS_FROZEN;
        end else if (!st.cmd[CMD_NO_QSTOP]) begin
            next_st.act.mode = DCS_QUICK_STOP;
        end else if (!st.cmd[CMD_START]) begin
            next_st.act.mode = DCS_RAMP_STOP;
        end else begin
            next_st.act.mode = DCS_RUN;
        end

        // frozen speed keeps last value; no reference update reaches it
        if (next_st.act.mode != DCS_FROZEN) begin
            if (st.cmd[CMD_JOG]) begin
                next_st.act.speedRef = jogSpeed;
            end else if (st.cmd[CMD_REF_HI] | st.cmd[CMD_REF_LO]) begin
                next_st.act.speedRef = selRef;
            end else begin
                next_st.act.speedRef = st.ref16;
            end
        end
        next_st.actual = outputFreq;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign act = st.act;
    assign actualValueWord = st.actual;

    sequence s_rise;
        $rose(st.cmd[CMD_RESET]);
    endsequence

    property p_reset_edge;
        @(posedge clk) disable iff (!arst_n)
        s_rise |=> act.tripReset ##1 !act.tripReset;
    endproperty
    a_reset_edge: assert property (p_reset_edge)
        else $error("trip reset not a single pulse on edge");

    property p_reset_level;
        @(posedge clk) disable iff (!arst_n)
        $stable(st.cmd[CMD_RESET]) |=> !act.tripReset;
    endproperty
    a_reset_level: assert property (p_reset_level)
        else $error("trip reset without rising edge");

    property p_invalid_ignored;
        @(posedge clk) disable iff (!arst_n)
        (cmdStrobe && !commandWord[CMD_VALID]) |=> $stable(st.cmd);
    endproperty
    a_invalid_ignored: assert property (p_invalid_ignored)
        else $error("invalid command word was taken");

    property p_capture;
        @(posedge clk) disable iff (!arst_n)
        (cmdStrobe && commandWord[CMD_VALID])
            |=> st.cmd == $past(commandWord)
                && st.ref16 == $past(busReference);
    endproperty
    a_capture: assert property (p_capture)
        else $error("command and reference not captured together");

    property p_coast;
        @(posedge clk) disable iff (!arst_n)
        !st.cmd[CMD_NO_COAST] |=> !act.outputEnable;
    endproperty
    a_coast: assert property (p_coast)
        else $error("output stage on while coasting");

    property p_dcbrake;
        @(posedge clk) disable iff (!arst_n)
        (st.cmd[CMD_NO_COAST] && !st.cmd[CMD_NO_DCBRK] && !cfg.dinCoast
            && !cfg.dinResetCoast) |=> act.mode == DCS_DC_BRAKE;
    endproperty
    a_dcbrake: assert property (p_dcbrake)
        else $error("dc brake not applied");

    property p_frozen;
        @(posedge clk) disable iff (!arst_n)
        act.mode == DCS_FROZEN |-> $stable(act.speedRef);
    endproperty
    a_frozen: assert property (p_frozen)
        else $error("frozen speed reference changed");

    property p_relay1;
        @(posedge clk) disable iff (!arst_n)
        (cfg.relay1Fn != RELAY1_FN_CW11) |=> !act.relay1;
    endproperty
    a_relay1: assert property (p_relay1)
        else $error("relay 1 driven while not configured");

    property p_rev_din;
        @(posedge clk) disable iff (!arst_n)
        (cfg.revSrc == DCS_REV_DIN && !cfg.revInput) |=> !act.reverse;
    endproperty
    a_rev_din: assert property (p_rev_din)
        else $error("reverse bit honoured with input source");

    property p_quick;
        @(posedge clk) disable iff (!arst_n)
        (st.cmd[CMD_NO_COAST] && st.cmd[CMD_NO_DCBRK] && st.cmd[CMD_NO_HOLD]
            && !st.cmd[CMD_NO_QSTOP] && !cfg.dinCoast && !cfg.dinDcBrake
            && !cfg.dinResetCoast) |=> act.mode == DCS_QUICK_STOP;
    endproperty
    a_quick: assert property (p_quick)
        else $error("quick stop not taken");
endmodule

/* File: hw/dcs_pkg.sv */
// Functional notes
// - command bits 1..0 pick one of four preset references; here 00 gives the bus reference, not preset 0.
// - bit 2 low applies dc braking and stop; high allows ramping.
// - bit 3 low disables output stage at once, motor coasts.
// - bit 4 low ramps to standstill with the quick-stop ramp.
// - bit 5 low freezes output frequency; reference updates ignored.
// - while frozen only coast, dc brake or input stop requests stop it.
// - bit 6 low ramps to stop with selected ramp-down time.
// - trip reset only on a rising edge of bit 7.
// - bit 8 high runs at jog speed instead of the reference.
// - bit 9 selects ramp pair one or two.
// - bit 10 low makes the whole command word ignored.
// - bits 11 and 12 drive relays 1 and 4 when so configured.
// - bits 14..13 select set-up one to four in multi set-up mode.
// - bit 15 reverses only when reverse source is serial, or, and.
// - status bit 0 is control ready, zero when tripped.
// - status bits 3, 4, 6 flag trip, error, trip lock.
// - status bit 7 flags warning; bit 5 reserved zero.
// - status bit 8 at speed; bit 9 low when local control.
// - bit 11 start or frequency above zero; bit 10 within limits.
// - bits 12..15 overtemp stop, dc link, torque, thermal timer.
// - lost link or internal comm fault forces status word to zero.
// - references signed 16-bit, 16384 is full scale, same for actual.
package dcs_pkg;
    localparam int CMD_REF_LO   = 0;
    localparam int CMD_REF_HI   = 1;
    localparam int CMD_NO_DCBRK = 2;
    localparam int CMD_NO_COAST = 3;
    localparam int CMD_NO_QSTOP = 4;
    localparam int CMD_NO_HOLD  = 5;
    localparam int CMD_START    = 6;
    localparam int CMD_RESET    = 7;
    localparam int CMD_JOG      = 8;
    localparam int CMD_RAMP2    = 9;
    localparam int CMD_VALID    = 10;
    localparam int CMD_RELAY1   = 11;
    localparam int CMD_RELAY4   = 12;
    localparam int CMD_SETUP_LO = 13;
    localparam int CMD_SETUP_HI = 14;
    localparam int CMD_REVERSE  = 15;

    localparam logic [15:0] CMD_RESET_VAL  = 16'h0000;
    localparam logic [15:0] FULL_SCALE     = 16'h4000;
    localparam logic [5:0]  RELAY1_FN_CW11 = 6'h24;
    localparam logic [5:0]  RELAY4_FN_CW12 = 6'h25;
    localparam logic [3:0]  SETUP_MULTI    = 4'h9;

    typedef enum logic [1:0] {
        DCS_REV_DIN, DCS_REV_SERIAL, DCS_REV_OR, DCS_REV_AND
    } dcs_rev_src_t;

    typedef enum logic [2:0] {
        DCS_STOPPED, DCS_RUN, DCS_RAMP_STOP, DCS_QUICK_STOP,
        DCS_DC_BRAKE, DCS_COAST, DCS_FROZEN
    } dcs_mode_t;

    typedef struct packed {
        logic [5:0]   relay1Fn;
        logic [5:0]   relay4Fn;
        logic [3:0]   activeSetup;
        dcs_rev_src_t revSrc;
        logic         revInput;
        logic         dinDcBrake;
        logic         dinCoast;
        logic         dinResetCoast;
    } dcs_cfg_t;

    typedef struct packed {
        logic trip;
        logic errNoTrip;
        logic tripLock;
        logic warning;
        logic atSpeed;
        logic localStop;
        logic refSiteLocal;
        logic startSignal;
        logic freqAboveZero;
        logic freqInLimits;
        logic overTempStop;
        logic dcLinkOut;
        logic torqueLimit;
        logic thermalTimer;
        logic commLost;
        logic commFault;
    } dcs_drv_stat_t;

    typedef struct packed {
        dcs_mode_t   mode;
        logic [1:0]  presetSel;
        logic        jog;
        logic        ramp2;
        logic        reverse;
        logic        relay1;
        logic        relay4;
        logic [1:0]  setupSel;
        logic        tripReset;
        logic        outputEnable;
        logic        rampEnable;
        logic [15:0] speedRef;
    } dcs_act_t;
endpackage

/* File: hw/dcs_status_word.sv */
`timescale 1ns/1ps
module dcs_status_word
    import dcs_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           arst_n,
    input  dcs_pkg::dcs_drv_stat_t drv,
    output logic [15:0]         statusWord
);
    logic [15:0] next_statusWord;

    always_comb begin
        next_statusWord = 16'h0000;
        next_statusWord[0]  = ~drv.trip;
        next_statusWord[3]  = drv.trip;
        next_statusWord[4]  = drv.errNoTrip;
        next_statusWord[6]  = drv.tripLock;
        next_statusWord[7]  = drv.warning;
        next_statusWord[8]  = drv.atSpeed;
        next_statusWord[9]  = ~(drv.localStop | drv.refSiteLocal);
        next_statusWord[10] = drv.freqInLimits;
        next_statusWord[11] = drv.startSignal | drv.freqAboveZero;
        next_statusWord[12] = drv.overTempStop;
        next_statusWord[13] = drv.dcLinkOut;
        next_statusWord[14] = drv.torqueLimit;
        next_statusWord[15] = drv.thermalTimer;
        if (drv.commLost || drv.commFault) begin
            next_statusWord = 16'h0000;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            statusWord <= 16'h0000;
        end else begin
            statusWord <= next_statusWord;
        end
    end

    property p_comm_zero;
        @(posedge clk) disable iff (!arst_n)
        (drv.commLost || drv.commFault) |=> statusWord == 16'h0000;
    endproperty
    a_comm_zero: assert property (p_comm_zero)
        else $error("status word not zero on comm loss");

    property p_ready_trip;
        @(posedge clk) disable iff (!arst_n)
        (!drv.commLost && !drv.commFault)
            |=> statusWord[0] == !$past(drv.trip)
                && statusWord[3] == $past(drv.trip);
    endproperty
    a_ready_trip: assert property (p_ready_trip)
        else $error("ready and trip bits disagree");

    property p_reserved;
        @(posedge clk) disable iff (!arst_n)
        1'b1 |=> statusWord[5] == 1'b0;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved status bit set");

    property p_bus_ctl;
        @(posedge clk) disable iff (!arst_n)
        (drv.localStop || drv.refSiteLocal) |=> !statusWord[9];
    endproperty
    a_bus_ctl: assert property (p_bus_ctl)
        else $error("bus control shown while local");
endmodule

/* File: verification/dcs_master_model.sv */
`timescale 1ns/1ps
// stands in for the bus master that sends telegrams
module dcs_master_model (
    output logic        cmdStrobe,
    output logic [15:0] commandWord,
    output logic [15:0] busReference
);
    initial begin
        cmdStrobe    = 1'b0;
        commandWord  = 16'h0000;
        busReference = 16'h0000;
    end
    // word and reference go out as one unit, bits 15..0 together
    task automatic put(input logic [15:0] w, input logic [15:0] r);
        cmdStrobe    <= 1'b1;
        commandWord  <= w;
        busReference <= r;
    endtask
    // released lines flip so a late capture cannot look right by chance
    task automatic release_bus();
        cmdStrobe    <= 1'b0;
        commandWord  <= ~commandWord;
        busReference <= ~busReference;
    endtask
endmodule

/* File: verification/drive_control_status_word_bench.sv */
`timescale 1ns/1ps
module drive_control_status_word_bench;
    import dcs_pkg::*;
    typedef struct {
        int          due;
        int          kind;
        logic [15:0] exp;
        logic [15:0] mask;
    } dcs_note_t;
    logic          clk;
    logic          arst_n;
    logic          cmdStrobe;
    logic [15:0]   commandWord;
    logic [15:0]   busReference;
    logic [15:0]   pre [4];
    logic [15:0]   jogSpeed;
    logic [15:0]   outputFreq;
    dcs_cfg_t      cfg;
    dcs_drv_stat_t drv;
    dcs_act_t      act;
    logic [15:0]   statusWord;
    logic [15:0]   actualValueWord;
    logic [15:0]   pw;
    logic [15:0]   emisc;
    logic [15:0]   eref;
    logic [15:0]   rw;
    logic [1:0]    es;
    logic          erev;
    dcs_mode_t     em;
    logic [31:0]   rnd;
    int            fails;
    int            n_tests;
    int            ncyc;
    int            seed = 94093;
    int            i;
    int            k;
    dcs_note_t     q[$];
    // {din brake, din coast, din reset-coast}, word, reference
    logic [34:0]   dt [10] = '{
        {3'b000, 16'h7C7F, 16'h1111}, {3'b000, 16'h047C, 16'hC000},
        {3'b000, 16'h057D, 16'h2000}, {3'b000, 16'h84FF, 16'h4000},
        {3'b000, 16'h04FF, 16'h4000}, {3'b000, 16'h007F, 16'h0123},
        {3'b000, 16'h04FF, 16'h4000}, {3'b010, 16'h045F, 16'h0000},
        {3'b100, 16'h045F, 16'h0000}, {3'b000, 16'h045F, 16'h0000}};

    dcs_master_model dcs_master_model_i (
        .cmdStrobe    (cmdStrobe),
        .commandWord  (commandWord),
        .busReference (busReference)
    );
    dcs_control dcs_control_i (
        .clk             (clk),
        .arst_n          (arst_n),
        .cmdStrobe       (cmdStrobe),
        .commandWord     (commandWord),
        .busReference    (busReference),
        .presetRef0      (pre[0]),
        .presetRef1      (pre[1]),
        .presetRef2      (pre[2]),
        .presetRef3      (pre[3]),
        .jogSpeed        (jogSpeed),
        .outputFreq      (outputFreq),
        .cfg             (cfg),
        .drv             (drv),
        .act             (act),
        .statusWord      (statusWord),
        .actualValueWord (actualValueWord)
    );

    initial clk = 1'b0;
    always #50 clk = ~clk;

    task automatic note(input int d, input int c, input logic [15:0] e,
                        input logic [15:0] m);
        q.push_back('{ncyc + d, c, e, m});
    endtask
    task automatic report(input logic [15:0] got, input dcs_note_t n);
        n_tests++;
        if ((got & n.mask) !== (n.exp & n.mask)) begin
            fails++;
            $display("BAD t=%0t kind %0d got %h exp %h", $time, n.kind,
                     got, n.exp);
        end
    endtask
    function automatic logic [15:0] misc(input dcs_act_t a);
        return {6'h00, a.presetSel, a.jog, a.ramp2, a.reverse, a.relay1,
                a.relay4, a.setupSel, a.tripReset};
    endfunction
    task automatic cmp_act(input dcs_note_t n);
        if (n.kind == 0) report({11'h000, act.outputEnable, act.rampEnable,
                                 act.mode}, n);
        else if (n.kind == 1) report(misc(act), n);
        else report(act.speedRef, n);
    endtask
    task automatic cmp_word(input dcs_note_t n);
        report(n.kind == 3 ? statusWord : actualValueWord, n);
    endtask
    task automatic print_verdict();
        $display("checks %0d fails %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic idle(input int n);
        @(posedge clk);
        dcs_master_model_i.release_bus();
        repeat (n - 1) @(posedge clk);
    endtask
    // stop priority: coast, dc brake, hold, quick stop, ramp stop
    function automatic dcs_mode_t mode_of(input logic [15:0] w);
        if (!w[CMD_NO_COAST] | cfg.dinCoast | cfg.dinResetCoast)
            return DCS_COAST;
        if (!w[CMD_NO_DCBRK] | cfg.dinDcBrake) return DCS_DC_BRAKE;
        if (!w[CMD_NO_HOLD]) return DCS_FROZEN;
        if (!w[CMD_NO_QSTOP]) return DCS_QUICK_STOP;
        if (!w[CMD_START]) return DCS_RAMP_STOP;
        return DCS_RUN;
    endfunction
    task automatic send(input logic [15:0] w, input logic [15:0] r);
        logic [15:0] f;
        logic        tr;
        logic [15:0] mw;
        f  = 16'($random(seed));
        tr = 1'b0;
        @(posedge clk);
        dcs_master_model_i.put(w, r);
        outputFreq <= f;
        // actual value is one register away, act two
        note(2, 4, f, 16'hFFFF);
        if (w[CMD_VALID]) begin
            tr = w[CMD_RESET] & ~pw[CMD_RESET];
            pw = w;
            eref = w[CMD_JOG] ? jogSpeed : (w[1:0] != 2'b00 ? pre[w[1:0]] : r);
        end
        // config may have moved since the last valid word: rebuild from it
        em = mode_of(pw);
        if (cfg.revSrc == DCS_REV_DIN) erev = cfg.revInput;
        else if (cfg.revSrc == DCS_REV_SERIAL) erev = pw[CMD_REVERSE];
        else if (cfg.revSrc == DCS_REV_OR)
            erev = pw[CMD_REVERSE] | cfg.revInput;
        else erev = pw[CMD_REVERSE] & cfg.revInput;
        if (cfg.activeSetup == SETUP_MULTI) es = pw[14:13];
        emisc = {6'h00, pw[1:0], pw[CMD_JOG], pw[CMD_RAMP2], erev,
                 pw[CMD_RELAY1] & (cfg.relay1Fn == RELAY1_FN_CW11),
                 pw[CMD_RELAY4] & (cfg.relay4Fn == RELAY4_FN_CW12), es, tr};
        mw = {11'h000, em != DCS_COAST,
              em != DCS_COAST && em != DCS_DC_BRAKE, em};
        note(3, 1, emisc, 16'hFFFF);
        note(3, 0, mw, 16'hFFFF);
        if (em != DCS_FROZEN) note(3, 2, eref, 16'hFFFF);
        if (tr) begin
            emisc[0] = 1'b0;
            note(4, 1, emisc, 16'hFFFF);
            @(posedge clk);
            dcs_master_model_i.release_bus();
        end
    endtask
    task automatic stat_step();
        dcs_drv_stat_t d;
        logic [15:0]   e;
        rnd = $random(seed);
        d = rnd[15:0];
        d.commLost  = d.commLost & rnd[16] & rnd[17];
        d.commFault = d.commFault & rnd[18] & rnd[19];
        e = {d.thermalTimer, d.torqueLimit, d.dcLinkOut, d.overTempStop,
             d.startSignal | d.freqAboveZero, d.freqInLimits,
             ~(d.localStop | d.refSiteLocal), d.atSpeed, d.warning,
             d.tripLock, 1'b0, d.errNoTrip, d.trip, 2'b00, ~d.trip};
        if (d.commLost | d.commFault) e = 16'h0000;
        @(posedge clk);
        drv <= d;
        note(2, 3, e, 16'hFFF9);
    endtask
    task automatic do_reset();
        @(posedge clk);
        arst_n <= 1'b0;
        drv    <= '0;
        note(2, 0, 16'h0000, 16'hFFFF);
        note(2, 1, 16'h0000, 16'hFFFF);
        note(2, 3, 16'h0000, 16'hFFFF);
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        pw = '0;
        em = DCS_STOPPED;
        emisc = '0;
        eref = '0;
        es = '0;
        erev = 1'b0;
    endtask

    // scan the whole queue: notes of different kinds fall due out of order
    always @(negedge clk) begin
        ncyc++;
        i = 0;
        while (i < q.size()) begin
            if (q[i].due == ncyc) begin
                if (q[i].kind > 2) cmp_word(q[i]);
                else cmp_act(q[i]);
                q.delete(i);
            end else i++;
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        print_verdict();
    end

    initial begin
        arst_n = 1'b0;
        cfg = '0;
        drv = '0;
        outputFreq = 16'h0000;
        fails = 0;
        n_tests = 0;
        ncyc = 0;
        jogSpeed = 16'($random(seed));
        for (k = 0; k < 4; k++) pre[k] = 16'($random(seed));
        do_reset();
        cfg.relay1Fn <= RELAY1_FN_CW11;
        cfg.relay4Fn <= RELAY4_FN_CW12;
        cfg.activeSetup <= SETUP_MULTI;
        cfg.revSrc <= DCS_REV_SERIAL;
        for (k = 0; k < 10; k++) begin
            idle(3);
            {cfg.dinDcBrake, cfg.dinCoast, cfg.dinResetCoast} <= dt[k][34:32];
            send(dt[k][31:16], dt[k][15:0]);
        end
        for (k = 0; k < 48; k++) begin
            if (k % 8 == 0) begin
                idle(3);
                rnd = $random(seed);
                cfg.relay1Fn <= rnd[0] ? RELAY1_FN_CW11 : rnd[13:8];
                cfg.relay4Fn <= rnd[14] ? RELAY4_FN_CW12 : rnd[20:15];
                cfg.activeSetup <= rnd[1] ? SETUP_MULTI : {rnd[7:5], 1'b0};
                cfg.revSrc <= dcs_rev_src_t'(rnd[3:2]);
                cfg.revInput <= rnd[4];
            end
            rnd = $random(seed);
            rw = rnd[15:0];
            rw[CMD_VALID] = |rnd[17:16];
            if (rnd[18]) rw[6:2] = 5'h1F;
            send(rw, rnd[31:16]);
        end
        idle(6);
        repeat (40) stat_step();
        idle(4);
        do_reset();
        send(16'h047F, 16'h3000);
        idle(8);
        n_tests++;
        if (q.size() != 0) begin
            fails++;
            $display("BAD t=%0t left %h exp %h", $time, q.size(), 0);
        end
        print_verdict();
    end
endmodule
